/* File: hw/imask_gating.v */
// interrupt mask gating stage with mask and priority command word entry
`timescale 1ns/1ns
`include "imask_defines.vh"
// Contract
// - a set mask bit stops that line from requesting interrupts
// - a clear mask bit lets that line reach priority resolution
// - mask gates the latched request, never the latch input
// - masked lines still set their request latch bit
// - pending masked request fires once its mask bit clears
// - read with register select high returns the mask on the port that reads
// - priority command word accepted for priority and end of interrupt
// - rotate, specific level and eoi bits decoded as one 3-bit code
// - select high picks mask; low with d4,d3 00 picks priority word
// - command words accepted any time after initialization
module imask_gating
(
    input wire clock,
    input wire nrst,
    input wire [`IMASK_LINES-1:0] request_line,
    input wire [`IMASK_LINES-1:0] request_clear,
    input wire init_done,
    input wire master_wr,
    input wire master_rd,
    input wire slave_wr,
    input wire slave_rd,
    input wire register_select_line,
    input wire [`IMASK_WORD_W-1:0] wdata,
    output reg [`IMASK_WORD_W-1:0] master_rdata_q,
    output reg [`IMASK_WORD_W-1:0] slave_rdata_q,
    output wire [`IMASK_LINES-1:0] gated_request,
    output wire int_request,
    output reg pcw_valid_q,
    output reg [2:0] pcw_instr_q,
    output reg [2:0] pcw_level_q,
    output reg tcw_valid_q,
    output reg [`IMASK_WORD_W-1:0] tcw_data_q
);
    reg [`IMASK_LINES-1:0] req_s1_q;
    reg [`IMASK_LINES-1:0] req_s2_q;
    reg [`IMASK_LINES-1:0] line_mask_bits_q;
    reg [`IMASK_LINES-1:0] line_mask_bits_d;
    reg pcw_valid_d;
    reg [2:0] pcw_instr_d;
    reg [2:0] pcw_level_d;
    reg tcw_valid_d;
    reg [`IMASK_WORD_W-1:0] tcw_data_d;
    reg [`IMASK_WORD_W-1:0] master_rdata_d;
    reg [`IMASK_WORD_W-1:0] slave_rdata_d;
    wire [`IMASK_LINES-1:0] latched;
    wire wr;
    wire [1:0] sel;
    wire mask_hit;
    wire pcw_hit;
    wire tcw_hit;
    wire master_rd_hit;
    wire slave_rd_hit;

    // read-back word: reserved upper bits always zero
    function [`IMASK_WORD_W-1:0] mask_word;
        input [`IMASK_LINES-1:0] mask;
        begin
            mask_word = {8'h00, mask};
        end
    endfunction

    // command word select field from data bits four and three
    function [1:0] word_select;
        input [`IMASK_WORD_W-1:0] d;
        begin
            word_select = {d[`IMASK_SEL_D4_BIT], d[`IMASK_SEL_D3_BIT]};
        end
    endfunction

    // rotate, specific level and eoi as one instruction code
    function [2:0] instr_code;
        input [`IMASK_WORD_W-1:0] d;
        begin
            instr_code = {d[`IMASK_PCW_R_BIT], d[`IMASK_PCW_SL_BIT],
                d[`IMASK_PCW_EOI_BIT]};
        end
    endfunction

    // request lines are pins: two-flop synchroniser before use
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            req_s1_q <= 8'h00;
            req_s2_q <= 8'h00;
        end
        else
        begin
            req_s1_q <= request_line;
            req_s2_q <= req_s1_q;
        end
    end

    imask_request_latch imask_request_latch_i
    (
        .clock(clock),
        .nrst(nrst),
        .set_lines(req_s2_q),
        .clear_lines(request_clear),
        .latched_q(latched)
    );

    // gating acts on the latch output only
    assign gated_request = latched & ~line_mask_bits_q;
    assign int_request = |gated_request;

    // decode of the port cycle; writes ignored until initialised
    assign wr = (master_wr | slave_wr) & init_done;
    assign sel = word_select(wdata);
    assign mask_hit = wr & register_select_line;
    assign pcw_hit = wr & ~register_select_line
        & (sel == `IMASK_SEL_PCW);
    assign tcw_hit = wr & ~register_select_line
        & (sel == `IMASK_SEL_TCW);
    assign master_rd_hit = master_rd & register_select_line;
    assign slave_rd_hit = slave_rd & register_select_line;

    // either port may rewrite the mask
    always @*
    begin
        line_mask_bits_d = line_mask_bits_q;
        if (mask_hit)
            line_mask_bits_d = wdata[`IMASK_LINES-1:0];
    end

    // instruction and level held until the next priority word
    always @*
    begin
        pcw_valid_d = pcw_hit;
        pcw_instr_d = pcw_instr_q;
        pcw_level_d = pcw_level_q;
        if (pcw_hit)
        begin
            pcw_instr_d = instr_code(wdata);
            pcw_level_d = wdata[2:0];
        end
    end

    // third word data held until the next third word
    always @*
    begin
        tcw_valid_d = tcw_hit;
        tcw_data_d = tcw_data_q;
        if (tcw_hit)
            tcw_data_d = wdata;
    end

    // read data holds until the next read with select high
    always @*
    begin
        master_rdata_d = master_rdata_q;
        slave_rdata_d = slave_rdata_q;
        if (master_rd_hit)
            master_rdata_d = mask_word(line_mask_bits_q);
        if (slave_rd_hit)
            slave_rdata_d = mask_word(line_mask_bits_q);
    end

    // mask register; reset value is a choice, software rewrites it
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            line_mask_bits_q <= `IMASK_MASK_RESET;
        else
            line_mask_bits_q <= line_mask_bits_d;
    end

    // priority command word capture, valid pulses for one cycle
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pcw_valid_q <= 1'b0;
            pcw_instr_q <= 3'h0;
            pcw_level_q <= 3'h0;
        end
        else
        begin
            pcw_valid_q <= pcw_valid_d;
            pcw_instr_q <= pcw_instr_d;
            pcw_level_q <= pcw_level_d;
        end
    end

    // third command word is captured and handed on untouched
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tcw_valid_q <= 1'b0;
            tcw_data_q <= 16'h0000;
        end
        else
        begin
            tcw_valid_q <= tcw_valid_d;
            tcw_data_q <= tcw_data_d;
        end
    end

    // master port read data
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            master_rdata_q <= 16'h0000;
        else
            master_rdata_q <= master_rdata_d;
    end

    // slave port read data
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            slave_rdata_q <= 16'h0000;
        else
            slave_rdata_q <= slave_rdata_d;
    end
endmodule

/* File: common/imask_defines.vh */
// constants for the interrupt mask gating block
`ifndef IMASK_DEFINES_VH
`define IMASK_DEFINES_VH
`define IMASK_LINES 8
`define IMASK_WORD_W 16
`define IMASK_MASK_RESET 8'h00
`define IMASK_PCW_EOI_BIT 5
`define IMASK_PCW_SL_BIT 6
`define IMASK_PCW_R_BIT 7
`define IMASK_SEL_D3_BIT 3
`define IMASK_SEL_D4_BIT 4
`define IMASK_SEL_PCW 2'b00
`define IMASK_SEL_TCW 2'b01
`endif

/* File: hw/imask_request_latch.v */
// interrupt request latch, set by request lines, cleared per line
`timescale 1ns/1ns
`include "imask_defines.vh"
module imask_request_latch
(
    input wire clock,
    input wire nrst,
    input wire [`IMASK_LINES-1:0] set_lines,
    input wire [`IMASK_LINES-1:0] clear_lines,
    output reg [`IMASK_LINES-1:0] latched_q
);
    // set wins over clear; latch input is never gated by the mask
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            latched_q <= 8'h00;
        else
            latched_q <= (latched_q & ~clear_lines) | set_lines;
    end
endmodule

/* File: sim/imask_gating_props.sv */
// assertion checker for the mask gating block
`timescale 1ns/1ns
module imask_props
(
    input wire clock,
    input wire nrst,
    input wire init_done,
    input wire master_wr,
    input wire slave_wr,
    input wire master_rd,
    input wire register_select_line,
    input wire int_request,
    input wire pcw_valid_q,
    input wire tcw_valid_q,
    input wire [15:0] wdata,
    input wire [15:0] master_rdata_q,
    input wire [7:0] gated_request,
    input wire [2:0] pcw_instr_q
);
wire wr = (master_wr | slave_wr) & init_done;
wire sel = register_select_line;
wire cmd = wr & !sel & wdata[4:3] == 2'b00;
wire [2:0] code = wdata[7:5];
default clocking @(posedge clock); endclocking
default disable iff (!nrst);
AST_GATE: assert property (wr & sel |=> !(gated_request & $past(wdata)))
    else $error("masked line requests");
AST_INT: assert property (int_request == |gated_request)
    else $error("request not ored");
AST_RDHI: assert property (master_rd & sel |=> master_rdata_q[15:8] == 0)
    else $error("read upper bits");
AST_RDLO: assert property (master_rd & !sel |=> $stable(master_rdata_q))
    else $error("read with select low");
AST_PCW: assert property (cmd |=> pcw_valid_q && pcw_instr_q == $past(code))
    else $error("code not taken");
AST_ONLY: assert property (pcw_valid_q |-> $past(cmd))
    else $error("stray code pulse");
AST_TCW: assert property (wr & !sel & wdata[4:3] == 2'b01 |=> tcw_valid_q)
    else $error("third word lost");
AST_OFF: assert property (!init_done ##1 !init_done |-> !pcw_valid_q)
    else $error("write before init");
cover property (cmd);
cover property (wr & sel);
cover property (int_request);
endmodule

/* File: sim/imask_host.sv */
// processor core model issuing port cycles
`timescale 1ns/1ns
module imask_host
(
    input wire clock,
    output reg [3:0] strobe,
    output reg sel,
    output reg [15:0] wdata
);
initial {strobe, sel, wdata} = 0;
// strobe is master write, master read, slave write, slave read
task cyc(input [3:0] s, input v, input [15:0] d);
    begin
        @(posedge clock) #5;
        strobe = s;
        sel = v;
        wdata = d;
        @(posedge clock) #5;
        strobe = 0;
        wdata = ~d;
    end
endtask
endmodule

/* File: sim/imask_gating_test.sv */
// self-checking bench for the mask gating block
`timescale 1ns/1ns
module imask_gating_test;
reg clock = 0, nrst = 0, init_done = 0;
reg [7:0] req = 0, clr = 0;
wire [3:0] s;
wire sel, irq, pv, tv;
wire [15:0] wd, mrd, srd, td;
wire [7:0] gr;
wire [2:0] pi, pl;
int fail_count = 0, n_compared = 0, i;
imask_host imask_host_i (.clock(clock), .strobe(s), .sel(sel), .wdata(wd));
imask_gating imask_gating_i (.clock(clock), .nrst(nrst), .request_line(req),
    .request_clear(clr), .init_done(init_done), .master_wr(s[3]),
    .master_rd(s[2]), .slave_wr(s[1]), .slave_rd(s[0]),
    .register_select_line(sel), .wdata(wd), .master_rdata_q(mrd),
    .slave_rdata_q(srd), .gated_request(gr), .int_request(irq),
    .pcw_valid_q(pv), .pcw_instr_q(pi), .pcw_level_q(pl),
    .tcw_valid_q(tv), .tcw_data_q(td));
task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    end
endtask
task mask_hold;
    begin
        imask_host_i.cyc(4'h8, 1, 16'h00ff);
        req = 8'h3c;
        repeat (4) @(posedge clock);
        #5;
        chk("gated", gr, 0);
        chk("irq", irq, 0);
        imask_host_i.cyc(4'h1, 1, 0);
        chk("srd", srd, 16'h00ff);
        imask_host_i.cyc(4'h2, 1, 0);
        chk("gated", gr, 16'h003c);
        chk("irq", irq, 1);
        req = 0;
        repeat (3) @(posedge clock);
        #5 clr = 8'hff;
        @(posedge clock) #5 clr = 0;
        chk("cleared", {irq, gr}, 0);
    end
endtask
task cmd_codes;
    begin
        for (i = 0; i < 8; i++)
        begin
            imask_host_i.cyc(4'h8, 0, i << 5 | 3);
            chk("code", {pv, pi, pl}, 16'h0043 | i << 3);
        end
        imask_host_i.cyc(4'h2, 0, 16'h0008);
        chk("third", tv, 1);
        chk("third data", td, 16'h0008);
        imask_host_i.cyc(4'h8, 1, 16'h005a);
        imask_host_i.cyc(4'h4, 1, 0);
        chk("mrd", mrd, 16'h005a);
        imask_host_i.cyc(4'h2, 1, 16'h00a5);
        imask_host_i.cyc(4'h4, 0, 0);
        chk("mrd held", mrd, 16'h005a);
        init_done = 0;
        imask_host_i.cyc(4'h8, 0, 16'h00e0);
        chk("refused", pv, 0);
    end
endtask
task summarize;
    begin
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
endtask
initial forever #50 clock = ~clock;
initial
begin
    repeat (6) @(posedge clock);
    #5 nrst = 1;
    init_done = 1;
    mask_hold;
    cmd_codes;
    summarize;
end
endmodule
bind imask_gating imask_props imask_props_i (.clock(clock), .nrst(nrst),
    .init_done(init_done), .master_wr(master_wr), .slave_wr(slave_wr),
    .master_rd(master_rd), .register_select_line(register_select_line),
    .int_request(int_request), .pcw_valid_q(pcw_valid_q),
    .tcw_valid_q(tcw_valid_q), .wdata(wdata),
    .master_rdata_q(master_rdata_q), .gated_request(gated_request),
    .pcw_instr_q(pcw_instr_q));
